// File: design/tic_pkg.sv
package tic_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] OFS_FAMILY_TYPE = 8'h00;
  localparam logic [7:0] OFS_MASK_VERSION = 8'h01;
  localparam logic [7:0] OFS_NVM_ADDRESS = 8'h11;
  localparam logic [7:0] OFS_NVM_DATA = 8'h12;
  localparam logic [7:0] OFS_FRAME_START_LABEL = 8'h1C;
  localparam logic [7:0] OFS_FRAME_END_LABEL = 8'h1D;
  localparam logic [7:0] OFS_LINE_START_LABEL = 8'h1E;
  localparam logic [7:0] OFS_LINE_END_LABEL = 8'h1F;
  localparam logic [7:0] OFS_STRAP_CAPTURE = 8'h20;
  localparam logic [7:0] OFS_FIRST_FRAME_SEL = 8'h22;
  localparam logic [7:0] OFS_SECOND_FRAME_SEL = 8'h25;

  // Reset values.
  localparam logic [7:0] RST_NVM_ADDRESS = 8'h00;
  localparam logic [7:0] RST_NVM_DATA = 8'h00;
  localparam logic [7:0] RST_STRAP_CAPTURE = 8'h00;
  localparam logic [7:0] RST_FRAME_START_LABEL = 8'h1E;
  localparam logic [7:0] RST_FRAME_END_LABEL = 8'hE1;
  localparam logic [7:0] RST_LINE_START_LABEL = 8'hAA;
  localparam logic [7:0] RST_LINE_END_LABEL = 8'h55;
  localparam logic [7:0] RST_FIRST_FRAME_SEL = 8'h30;
  localparam logic [7:0] RST_SECOND_FRAME_SEL = 8'h35;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field positions.
  localparam int STRAP_LOW_BIT = 5;
  localparam int STRAP_HIGH_BIT = 6;
  localparam int SEL_FIELD_W = 2;
  localparam int SEL_FIRST_MOD_LSB = 0;
  localparam int SEL_SECOND_MOD_LSB = 2;

  // Shadowed registers, by index.
  localparam int NUM_SHADOW = 6;
  localparam logic [2:0] SH_FRAME_START = 3'h0;
  localparam logic [2:0] SH_FRAME_END = 3'h1;
  localparam logic [2:0] SH_LINE_START = 3'h2;
  localparam logic [2:0] SH_LINE_END = 3'h3;
  localparam logic [2:0] SH_FIRST_SEL = 3'h4;
  localparam logic [2:0] SH_SECOND_SEL = 3'h5;
  localparam logic [2:0] SH_NONE = 3'h7;
  localparam logic [NUM_SHADOW*8-1:0] SHADOW_RST = {RST_SECOND_FRAME_SEL, RST_FIRST_FRAME_SEL,
    RST_LINE_END_LABEL, RST_LINE_START_LABEL, RST_FRAME_END_LABEL, RST_FRAME_START_LABEL};

  // Strap scan phase length.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STRAP_SCAN_NS = 100;
  localparam int STRAP_SCAN_CYCLES = (STRAP_SCAN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    TIC_STRAP_RESET = 2'h0,
    TIC_STRAP_SCAN = 2'h1,
    TIC_STRAP_DONE = 2'h3
  } tic_strap_state_t;

  function automatic logic [2:0] shadow_index(input logic [7:0] addr);
    case (addr)
      OFS_FRAME_START_LABEL: shadow_index = SH_FRAME_START;
      OFS_FRAME_END_LABEL: shadow_index = SH_FRAME_END;
      OFS_LINE_START_LABEL: shadow_index = SH_LINE_START;
      OFS_LINE_END_LABEL: shadow_index = SH_LINE_END;
      OFS_FIRST_FRAME_SEL: shadow_index = SH_FIRST_SEL;
      OFS_SECOND_FRAME_SEL: shadow_index = SH_SECOND_SEL;
      default: shadow_index = SH_NONE;
    endcase
  endfunction : shadow_index

endpackage : tic_pkg

// File: design/tic_strap_scan.sv
`timescale 1ns/1ps
module tic_strap_scan #(
  parameter int SCAN_CYCLES = tic_pkg::STRAP_SCAN_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic strap_low,
  input wire logic strap_high,
  output logic captured_low,
  output logic captured_high,
  output logic capture_valid
);

  tic_pkg::tic_strap_state_t state;
  logic [15:0] scan_count;
  logic sample_low;
  logic sample_high;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= tic_pkg::TIC_STRAP_RESET;
      scan_count <= 16'h0000;
    end else begin
      case (state)
        tic_pkg::TIC_STRAP_RESET: begin
          state <= tic_pkg::TIC_STRAP_SCAN;
          scan_count <= 16'h0000;
        end
        tic_pkg::TIC_STRAP_SCAN: begin
          if (scan_count == 16'(SCAN_CYCLES - 1)) begin
            state <= tic_pkg::TIC_STRAP_DONE;
          end
          scan_count <= scan_count + 16'h0001;
        end
        tic_pkg::TIC_STRAP_DONE: begin
          state <= tic_pkg::TIC_STRAP_DONE;
        end
        default: begin
          state <= tic_pkg::TIC_STRAP_RESET;
        end
      endcase
    end
  end

  // The pins are sampled only after release, so a pull-up overrides the start-up zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_low <= 1'b0;
      sample_high <= 1'b0;
    end else if (state == tic_pkg::TIC_STRAP_SCAN) begin
      sample_low <= strap_low;
      sample_high <= strap_high;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      captured_low <= 1'b0;
      captured_high <= 1'b0;
      capture_valid <= 1'b0;
    end else if (state == tic_pkg::TIC_STRAP_DONE && !capture_valid) begin
      captured_low <= sample_low;
      captured_high <= sample_high;
      capture_valid <= 1'b1;
    end
  end

endmodule : tic_strap_scan

// File: design/tic_register_bank.sv
`timescale 1ns/1ps
module tic_register_bank #(
  parameter logic [7:0] FAMILY_TYPE = 8'hA5,
  parameter logic [7:0] MASK_VERSION = 8'h01,
  parameter int STRAP_SCAN_CYCLES = tic_pkg::STRAP_SCAN_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic program_loaded,
  input wire logic frame_active,
  input wire logic frame_start,
  input wire logic reg_addr_load,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic [7:0] reg_pointer,
  input wire logic nvm_data_update,
  input wire logic [7:0] nvm_data_in,
  output logic [7:0] nvm_address,
  output logic [7:0] nvm_data,
  output logic nvm_data_written,
  input wire logic bus_address_strap_low,
  input wire logic bus_address_strap_high,
  output logic strap_low_captured,
  output logic strap_high_captured,
  output logic strap_valid,
  output logic [7:0] frame_start_label,
  output logic [7:0] frame_end_label,
  output logic [7:0] line_start_label,
  output logic [7:0] line_end_label,
  output logic [1:0] first_frame_first_modulator,
  output logic [1:0] first_frame_second_modulator,
  output logic [1:0] second_frame_first_modulator,
  output logic [1:0] second_frame_second_modulator,
  output logic shadow_pending
);

  logic full_reset;
  logic [7:0] access_addr;
  logic [2:0] wr_index;
  logic [7:0] host_view [tic_pkg::NUM_SHADOW];
  logic [7:0] active_value [tic_pkg::NUM_SHADOW];
  logic [tic_pkg::NUM_SHADOW-1:0] pending;
  logic [7:0] next_rd_data;
  logic [7:0] strap_byte;
  logic nvm_address_wr;
  logic nvm_data_wr;

  // One decode for both nonvolatile write strobes keeps the address compare in a single place.
  function automatic logic write_hit(input logic en, input logic [7:0] addr, input logic [7:0] target);
    write_hit = en && (addr == target);
  endfunction : write_hit

  // Both selection registers share one field layout.
  function automatic logic [1:0] sel_field(input logic [7:0] sel_byte, input int lsb);
    sel_field = sel_byte[lsb +: tic_pkg::SEL_FIELD_W];
  endfunction : sel_field

  // Software reset behaves exactly like the hardware reset.
  assign full_reset = rst | soft_reset;

  // An address byte may arrive with its first data byte in the same cycle.
  assign access_addr = reg_addr_load ? reg_addr : reg_pointer;
  assign wr_index = tic_pkg::shadow_index(access_addr);

  // The data store and its notify pulse decode the same write.
  assign nvm_address_wr = write_hit(reg_wr_en, access_addr, tic_pkg::OFS_NVM_ADDRESS);
  assign nvm_data_wr = write_hit(reg_wr_en, access_addr, tic_pkg::OFS_NVM_DATA);

  // Pointer.
  always_ff @(posedge clk) begin
    if (full_reset) begin
      reg_pointer <= 8'h00;
    end else if (reg_wr_en || reg_rd_en) begin
      reg_pointer <= access_addr + 8'h01;
    end else if (reg_addr_load) begin
      reg_pointer <= reg_addr;
    end
  end

  // Shadowed registers: the host view updates at once, the active copy at once between frames and at frame start during a frame.
  genvar gi;
  generate
    for (gi = 0; gi < tic_pkg::NUM_SHADOW; gi++) begin : g_shadow
      localparam logic [7:0] RST_VAL = tic_pkg::SHADOW_RST[gi*8 +: 8];
      logic hit;
      assign hit = reg_wr_en && (wr_index == 3'(gi));

      always_ff @(posedge clk) begin
        if (full_reset || program_loaded) begin
          host_view[gi] <= RST_VAL;
        end else if (hit) begin
          host_view[gi] <= reg_wr_data;
        end
      end

      always_ff @(posedge clk) begin
        if (full_reset || program_loaded) begin
          active_value[gi] <= RST_VAL;
        end else if (hit && !frame_active) begin
          active_value[gi] <= reg_wr_data;
        end else if (frame_start && pending[gi]) begin
          active_value[gi] <= host_view[gi];
        end
      end

      // A write landing in the same cycle as the frame start stays pending.
      always_ff @(posedge clk) begin
        if (full_reset || program_loaded) begin
          pending[gi] <= 1'b0;
        end else if (hit && frame_active) begin
          pending[gi] <= 1'b1;
        end else if (hit || frame_start) begin
          pending[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (full_reset) begin
      shadow_pending <= 1'b0;
    end else begin
      shadow_pending <= |pending;
    end
  end

  // Consumers only ever see the active copies.
  always_ff @(posedge clk) begin
    if (full_reset) begin
      frame_start_label <= tic_pkg::RST_FRAME_START_LABEL;
    end else begin
      frame_start_label <= active_value[tic_pkg::SH_FRAME_START];
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      frame_end_label <= tic_pkg::RST_FRAME_END_LABEL;
    end else begin
      frame_end_label <= active_value[tic_pkg::SH_FRAME_END];
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      line_start_label <= tic_pkg::RST_LINE_START_LABEL;
    end else begin
      line_start_label <= active_value[tic_pkg::SH_LINE_START];
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      line_end_label <= tic_pkg::RST_LINE_END_LABEL;
    end else begin
      line_end_label <= active_value[tic_pkg::SH_LINE_END];
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      first_frame_first_modulator <= sel_field(tic_pkg::RST_FIRST_FRAME_SEL, tic_pkg::SEL_FIRST_MOD_LSB);
    end else begin
      first_frame_first_modulator <=
        sel_field(active_value[tic_pkg::SH_FIRST_SEL], tic_pkg::SEL_FIRST_MOD_LSB);
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      first_frame_second_modulator <= sel_field(tic_pkg::RST_FIRST_FRAME_SEL, tic_pkg::SEL_SECOND_MOD_LSB);
    end else begin
      first_frame_second_modulator <=
        sel_field(active_value[tic_pkg::SH_FIRST_SEL], tic_pkg::SEL_SECOND_MOD_LSB);
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      second_frame_first_modulator <= sel_field(tic_pkg::RST_SECOND_FRAME_SEL, tic_pkg::SEL_FIRST_MOD_LSB);
    end else begin
      second_frame_first_modulator <=
        sel_field(active_value[tic_pkg::SH_SECOND_SEL], tic_pkg::SEL_FIRST_MOD_LSB);
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      second_frame_second_modulator <= sel_field(tic_pkg::RST_SECOND_FRAME_SEL, tic_pkg::SEL_SECOND_MOD_LSB);
    end else begin
      second_frame_second_modulator <=
        sel_field(active_value[tic_pkg::SH_SECOND_SEL], tic_pkg::SEL_SECOND_MOD_LSB);
    end
  end

  // Indirect nonvolatile access pair; the engine may deposit read results in the data register.
  // These are not shadowed, so the host must keep them still while a frame runs.
  always_ff @(posedge clk) begin
    if (full_reset) begin
      nvm_address <= tic_pkg::RST_NVM_ADDRESS;
    end else if (nvm_address_wr) begin
      nvm_address <= reg_wr_data;
    end
  end

  // A host write wins over an engine update in the same cycle.
  always_ff @(posedge clk) begin
    if (full_reset) begin
      nvm_data <= tic_pkg::RST_NVM_DATA;
    end else if (nvm_data_wr) begin
      nvm_data <= reg_wr_data;
    end else if (nvm_data_update) begin
      nvm_data <= nvm_data_in;
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      nvm_data_written <= 1'b0;
    end else begin
      nvm_data_written <= nvm_data_wr;
    end
  end

  tic_strap_scan #(
    .SCAN_CYCLES(STRAP_SCAN_CYCLES)
  ) u_strap (
    .clk(clk),
    .rst(full_reset),
    .strap_low(bus_address_strap_low),
    .strap_high(bus_address_strap_high),
    .captured_low(strap_low_captured),
    .captured_high(strap_high_captured),
    .capture_valid(strap_valid)
  );

  always_comb begin
    strap_byte = tic_pkg::RST_STRAP_CAPTURE;
    strap_byte[tic_pkg::STRAP_LOW_BIT] = strap_low_captured;
    strap_byte[tic_pkg::STRAP_HIGH_BIT] = strap_high_captured;
  end

  // Read decode. Reads of a shadowed register return the last value the host wrote.
  // Identification and strap registers have no write path at all, so writes there fall through.
  always_comb begin
    next_rd_data = tic_pkg::UNMAPPED_READ;
    case (access_addr)
      tic_pkg::OFS_FAMILY_TYPE: next_rd_data = FAMILY_TYPE;
      tic_pkg::OFS_MASK_VERSION: next_rd_data = MASK_VERSION;
      tic_pkg::OFS_NVM_ADDRESS: next_rd_data = nvm_address;
      tic_pkg::OFS_NVM_DATA: next_rd_data = nvm_data;
      tic_pkg::OFS_STRAP_CAPTURE: next_rd_data = strap_byte;
      default: begin
        if (wr_index != tic_pkg::SH_NONE) begin
          next_rd_data = host_view[wr_index];
        end else begin
          next_rd_data = tic_pkg::UNMAPPED_READ;
        end
      end
    endcase
  end

  // A read answer stands for exactly one cycle; the data stay until the next read.
  always_ff @(posedge clk) begin
    if (full_reset) begin
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
    end
  end

  always_ff @(posedge clk) begin
    if (full_reset) begin
      reg_rd_data <= tic_pkg::UNMAPPED_READ;
    end else if (reg_rd_en) begin
      reg_rd_data <= next_rd_data;
    end
  end

endmodule : tic_register_bank

// File: testbench/tic_register_bank_sva.sv
`timescale 1ns/1ps
module tic_bank_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic frame_active,
  input wire logic frame_start,
  input wire logic reg_addr_load,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic reg_rd_valid,
  input wire logic [7:0] reg_pointer,
  input wire logic nvm_data_written,
  input wire logic strap_valid,
  input wire logic strap_low_captured,
  input wire logic strap_high_captured,
  input wire logic [7:0] frame_start_label,
  input wire logic [7:0] frame_end_label,
  input wire logic [7:0] line_start_label,
  input wire logic [7:0] line_end_label,
  input wire logic [1:0] first_frame_first_modulator,
  input wire logic [1:0] second_frame_second_modulator,
  input wire logic shadow_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || soft_reset);
  // Captured straps mean nothing until the pins have been sampled after release.
  sequence s_scan;
    !strap_valid [*2] ##[1:40] strap_valid;
  endsequence
  a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
  a_rd_cause: assert property (reg_rd_valid |-> $past(reg_rd_en)) else $error("spurious read valid");
  a_ptr_load: assert property (reg_addr_load && (reg_wr_en || reg_rd_en) |=>
    reg_pointer == $past(reg_addr) + 8'h01) else $error("pointer not past loaded address");
  a_ptr_step: assert property (!reg_addr_load && (reg_wr_en || reg_rd_en) |=>
    reg_pointer == $past(reg_pointer) + 8'h01) else $error("pointer did not advance");
  a_reset_vals: assert property ($fell(rst) |-> frame_start_label == 8'h1E && frame_end_label == 8'hE1
    && line_start_label == 8'hAA && line_end_label == 8'h55 && first_frame_first_modulator == 2'h0
    && second_frame_second_modulator == 2'h1) else $error("wrong reset outputs");
  a_strap_scan: assert property ($fell(rst) |-> s_scan) else $error("strap scan timing wrong");
  a_strap_hold: assert property (strap_valid |=> strap_valid && $stable(strap_low_captured)
    && $stable(strap_high_captured)) else $error("captured straps moved");
  a_shadow_wait: assert property (frame_active && !frame_start && reg_wr_en && reg_addr_load
    && reg_addr == 8'h22 |-> ##[1:2] shadow_pending) else $error("shadow write not held");
  a_nvm_pulse: assert property (reg_wr_en && reg_addr_load && reg_addr == 8'h12
    |-> ##[1:2] nvm_data_written) else $error("data write not signalled");
endmodule : tic_bank_sva
bind tic_register_bank tic_bank_sva u_sva (.*);

// File: testbench/tic_host_model.sv
`timescale 1ns/1ps
module tic_host_model (
  input wire logic clk,
  output logic reg_addr_load,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  initial begin
    reg_addr_load = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Callers write only mapped addresses, and non-shadowed ones only between frames.
  task automatic xfer(input logic ld, input logic [7:0] a, input logic wr, input logic [7:0] d,
      output logic [7:0] q, output logic v);
    @(negedge clk);
    reg_addr_load = ld;
    reg_addr = a;
    reg_wr_en = wr;
    reg_wr_data = d;
    reg_rd_en = !wr;
    @(negedge clk);
    q = reg_rd_data;
    v = reg_rd_valid;
    reg_addr_load = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask : xfer
endmodule : tic_host_model

// File: testbench/tic_register_bank_bench.sv
`timescale 1ns/1ps
module tic_register_bank_bench;
  localparam logic [7:0] FAM = 8'h5A; // Arbitrary value.
  localparam logic [7:0] MASK = 8'hC3; // Arbitrary value.
  logic clk = 1'b0, rst = 1'b1, soft_reset = 1'b0, program_loaded = 1'b0, frame_active = 1'b0;
  logic frame_start = 1'b0, nvm_data_update = 1'b0, bus_address_strap_low = 1'b0, bus_address_strap_high = 1'b0;
  logic [7:0] nvm_data_in = 8'h00;
  logic reg_addr_load, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, nvm_address, nvm_data;
  logic [7:0] frame_start_label, frame_end_label, line_start_label, line_end_label;
  logic [1:0] first_frame_first_modulator, first_frame_second_modulator;
  logic [1:0] second_frame_first_modulator, second_frame_second_modulator;
  int mdl [256];
  int failures = 0, num_checks = 0, cycles = 0, e22;
  logic [7:0] q8;
  logic v1;
  always #2.5 clk = ~clk;
  tic_register_bank #(.FAMILY_TYPE(FAM), .MASK_VERSION(MASK), .STRAP_SCAN_CYCLES(2)) u_dut (
    .reg_pointer(), .nvm_data_written(), .strap_low_captured(), .strap_high_captured(), .strap_valid(),
    .shadow_pending(), .*);
  tic_host_model u_host (.*);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // A stuck handshake would otherwise hang the run forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic void mdl_reset();
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = FAM;
    mdl[1] = MASK;
    mdl[8'h1C] = 8'h1E;
    mdl[8'h1D] = 8'hE1;
    mdl[8'h1E] = 8'hAA;
    mdl[8'h1F] = 8'h55;
    mdl[8'h20] = (bus_address_strap_high << 6) | (bus_address_strap_low << 5);
    mdl[8'h22] = 8'h30;
    mdl[8'h25] = 8'h35;
  endfunction : mdl_reset
  task automatic wrb(input logic [7:0] a, input int n);
    logic [7:0] q, d;
    logic v;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_host.xfer(i == 0, a + 8'(i), 1'b1, d, q, v);
      if (a + 8'(i) inside {8'h11, 8'h12, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h22, 8'h25}) mdl[a + 8'(i)] = d;
    end
  endtask : wrb
  task automatic rdb(input logic [7:0] a, input int n);
    logic [7:0] q;
    logic v;
    for (int i = 0; i < n; i++) begin
      u_host.xfer(i == 0, a + 8'(i), 1'b0, 8'h00, q, v);
      chk("rd_valid", {7'h00, v}, 8'h01);
      chk("rd_data", q, 8'(mdl[a + 8'(i)]));
    end
  endtask : rdb
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  initial begin
    void'($urandom(78829));
    bus_address_strap_low = 1'($urandom);
    bus_address_strap_high = 1'($urandom);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (30) @(negedge clk);
    mdl_reset();
    rdb(8'h00, 3);
    rdb(8'h11, 2);
    rdb(8'h1C, 10);
    $display("test reset_values done");
    wrb(8'h1C, 4);
    wrb(8'h11, 2);
    wrb(8'h12, 1);
    wrb(8'h22, 1);
    wrb(8'h25, 1);
    repeat (2) @(negedge clk);
    chk("fs_label", frame_start_label, 8'(mdl[8'h1C]));
    chk("le_label", line_end_label, 8'(mdl[8'h1F]));
    chk("sel1_m2", {6'h00, first_frame_second_modulator}, 8'(mdl[8'h22] >> 2 & 3));
    chk("sel2_m1", {6'h00, second_frame_first_modulator}, 8'(mdl[8'h25] & 3));
    chk("nvm_addr", nvm_address, 8'(mdl[8'h11]));
    chk("nvm_data", nvm_data, 8'(mdl[8'h12]));
    rdb(8'h11, 2);
    rdb(8'h1C, 4);
    rdb(8'h22, 4);
    nvm_data_in = 8'($urandom);
    mdl[8'h12] = nvm_data_in;
    pulse(nvm_data_update);
    rdb(8'h12, 1);
    rdb(8'hFF, 2);
    $display("test idle_writes done");
    wrb(8'h00, 2);
    wrb(8'h20, 1);
    rdb(8'h00, 2);
    rdb(8'h20, 1);
    $display("test read_only done");
    // The new selection differs in the low field, so a premature update cannot hide.
    e22 = mdl[8'h22];
    frame_active = 1'b1;
    mdl[8'h22] = e22 ^ 8'h03;
    u_host.xfer(1'b1, 8'h22, 1'b1, 8'(mdl[8'h22]), q8, v1);
    repeat (4) @(negedge clk);
    chk("sel1_m1", {6'h00, first_frame_first_modulator}, 8'(e22 & 3));
    pulse(frame_start);
    repeat (2) @(negedge clk);
    chk("sel1_m1", {6'h00, first_frame_first_modulator}, 8'(mdl[8'h22] & 3));
    frame_active = 1'b0;
    $display("test shadow done");
    wrb(8'h1C, 1);
    pulse(program_loaded);
    repeat (2) @(negedge clk);
    chk("fs_label", frame_start_label, 8'h1E);
    pulse(soft_reset);
    repeat (30) @(negedge clk);
    mdl_reset();
    rdb(8'h11, 2);
    rdb(8'h1C, 7);
    $display("test soft_reset done");
    tally_and_finish();
  end
endmodule : tic_register_bank_bench
